// ### rtl/ppc_spi_slave.sv
`timescale 1ns/1ps
`include "ppc_map.svh"

module ppc_spi_slave (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdio_i,
  input wire logic spi_3wire,
  output logic spi_sdio_o,
  output logic spi_sdio_oe,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire logic [7:0] reg_rdata
);
  import ppc_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // The port is oversampled, so the serial clock must stay well below
  // a quarter of mclk; edges are found between the second and third stages.
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q;
  logic sdi_s1_q, sdi_s2_q;
  logic m3_s1_q, m3_s2_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
      m3_s1_q <= 1'b0;
      m3_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= spi_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      sdi_s1_q <= spi_sdio_i;
      sdi_s2_q <= sdi_s1_q;
      m3_s1_q <= spi_3wire;
      m3_s2_q <= m3_s1_q;
    end
  end

  logic rise, fall;
  assign rise = sclk_s2_q & ~sclk_s3_q;
  assign fall = ~sclk_s2_q & sclk_s3_q;

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  ppc_spi_state_t state_q;
  logic [3:0] cnt_q;
  logic [6:0] sh_q;
  logic rd_q, load_q, wr_q;
  logic [6:0] addr_q;
  logic [7:0] wdata_q, out_q;

  always_ff @(posedge mclk) begin
    if (sys_rst || cs_s2_q) begin
      state_q <= PPC_SPI_CMD;
      cnt_q <= 4'h0;
      sh_q <= 7'h00;
      rd_q <= 1'b0;
      load_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 7'h00;
      wdata_q <= 8'h00;
    end else begin
      load_q <= 1'b0;
      wr_q <= 1'b0;
      if (rise && state_q != PPC_SPI_DONE) begin
        sh_q <= {sh_q[5:0], sdi_s2_q};
        cnt_q <= cnt_q + 4'h1;
        case (state_q)
          PPC_SPI_CMD: begin
            if (cnt_q == `PPC_CMD_LAST) begin
              rd_q <= sh_q[6];
              addr_q <= {sh_q[5:0], sdi_s2_q};
              load_q <= sh_q[6];
              state_q <= PPC_SPI_DATA;
            end
          end
          PPC_SPI_DATA: begin
            if (cnt_q == `PPC_DATA_LAST) begin
              wdata_q <= {sh_q, sdi_s2_q};
              wr_q <= ~rd_q; // RULE11
              state_q <= PPC_SPI_DONE;
            end
          end
          default: state_q <= PPC_SPI_DONE;
        endcase
      end
    end
  end

  // The fall that closes the address phase must not shift, or the top
  // bit would leave the pin before the master could sample it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_q <= 8'h00;
    end else if (load_q) begin
      out_q <= reg_rdata;
    end else if (fall && state_q == PPC_SPI_DATA && rd_q
                 && cnt_q != `PPC_DATA_FIRST) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  logic rd_phase;
  assign rd_phase = ~cs_s2_q & rd_q & (state_q == PPC_SPI_DATA);
  assign spi_sdio_o = out_q[7];
  assign spi_sdio_oe = rd_phase & m3_s2_q;
  assign spi_sdo_o = out_q[7];
  assign spi_sdo_oe = rd_phase & ~m3_s2_q;
  assign reg_addr = addr_q;
  assign reg_wdata = wdata_q;
  assign reg_wr = wr_q;

endmodule

// ### rtl/ppc_top.sv
`timescale 1ns/1ps
`include "ppc_map.svh"

module ppc_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdio_i,
  input wire logic spi_3wire,
  output logic spi_sdio_o,
  output logic spi_sdio_oe,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  output logic vcxo_tune_polarity,
  output logic force_midpoint_tune,
  output logic first_loop_lock_enable,
  output logic [5:0] pump_offset_code,
  output logic [18:0] pump_offset_na,
  output logic doubler_select,
  output logic [6:0] second_stage_predivider,
  output logic [6:0] predivide_ratio,
  output logic vcxo_limit_div_select,
  output logic [1:0] vcxo_feedback_mult,
  output logic ext_vco_limit_div_select,
  output logic [1:0] ext_vco_div_ratio,
  output ppc_pkg::ppc_source_t output_source_select,
  output ppc_pkg::ppc_source_t output_source_route,
  output logic output_source_invalid,
  output logic first_stage_bypass_mode
);
  import ppc_pkg::*;

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic [7:0] reg_rdata;

  ppc_spi_slave u_spi (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdio_i(spi_sdio_i),
    .spi_3wire(spi_3wire),
    .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe(spi_sdio_oe),
    .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe(spi_sdo_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  // ----------------------------------------
  // Offset current decode
  // ----------------------------------------
  function automatic logic [18:0] offset_na(input logic [5:0] c);
    logic [5:0] steps;
    steps = (c[5] ? `PPC_OFS_W5 : 6'h00)
          + (c[4] ? `PPC_OFS_W4 : 6'h00)
          + (c[3] ? `PPC_OFS_W3 : 6'h00)
          + (c[2] ? `PPC_OFS_W2 : 6'h00)
          + (c[1] ? `PPC_OFS_W1 : 6'h00)
          + (c[0] ? `PPC_OFS_W0 : 6'h00);
    offset_na = 19'({13'h0000, steps} * `PPC_OFS_STEP_NA);
  endfunction

  // ----------------------------------------
  // First-stage pump register
  // ----------------------------------------
  logic pol_q, force_q;
  logic [5:0] ofs_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pol_q <= `PPC_RST_POL; // RULE1
      force_q <= `PPC_RST_FORCE; // RULE2
      ofs_q <= `PPC_RST_OFFSET; // RULE4
    end else if (reg_wr && reg_addr == `PPC_ADDR_PUMP) begin
      pol_q <= reg_wdata[`PPC_PUMP_POL]; // RULE1
      force_q <= reg_wdata[`PPC_PUMP_FORCE]; // RULE3
      ofs_q <= reg_wdata[`PPC_PUMP_OFS_HI:0]; // RULE4
    end
  end

  // ----------------------------------------
  // Second-stage input register
  // ----------------------------------------
  logic dbl_q;
  logic [6:0] pdiv_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dbl_q <= `PPC_RST_DBL; // RULE5
      pdiv_q <= `PPC_RST_PREDIV; // RULE6
    end else if (reg_wr && reg_addr == `PPC_ADDR_PREDIV) begin
      dbl_q <= reg_wdata[`PPC_PREDIV_DBL]; // RULE5
      pdiv_q <= reg_wdata[`PPC_PREDIV_HI:0]; // RULE6
    end
  end

  // ----------------------------------------
  // Path select register
  // ----------------------------------------
  logic vcxo_q, extv_q, byp_q;
  logic [1:0] src_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vcxo_q <= `PPC_RST_VCXO; // RULE7
      extv_q <= `PPC_RST_EXTV; // RULE8
      src_q <= `PPC_RST_SRC; // RULE9
      byp_q <= `PPC_RST_BYP; // RULE10
    end else if (reg_wr && reg_addr == `PPC_ADDR_PATH) begin
      vcxo_q <= reg_wdata[`PPC_PATH_VCXO]; // RULE7
      extv_q <= reg_wdata[`PPC_PATH_EXTV]; // RULE8
      src_q <= reg_wdata[`PPC_PATH_SRC_HI:`PPC_PATH_SRC_LO]; // RULE9
      byp_q <= reg_wdata[`PPC_PATH_BYP]; // RULE10
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Reserved positions and unmapped addresses read back as zero.
  always_comb begin
    if (reg_addr == `PPC_ADDR_PUMP) begin
      reg_rdata = {pol_q, force_q, ofs_q};
    end else if (reg_addr == `PPC_ADDR_PREDIV) begin
      reg_rdata = {dbl_q, pdiv_q};
    end else if (reg_addr == `PPC_ADDR_PATH) begin
      reg_rdata = {vcxo_q, extv_q, src_q, byp_q, 3'h0}; // RULE11
    end else begin
      reg_rdata = 8'h00;
    end
  end

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  // Derived values are registered so the analog controls see one clean
  // change per write; they lag the raw fields by one cycle.
  logic [18:0] ofs_na_q;
  logic [6:0] ratio_q;
  logic [1:0] fb_mult_q, extv_div_q;
  logic lock_en_q, src_bad_q;
  ppc_source_t route_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ofs_na_q <= 19'h00000;
      lock_en_q <= 1'b0;
    end else begin
      ofs_na_q <= offset_na(ofs_q); // RULE4
      lock_en_q <= ~force_q; // RULE2
    end
  end

  // A predivider of zero has no meaning; it is treated as a bypass.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ratio_q <= `PPC_DIV_BY_ONE;
    end else if (dbl_q || pdiv_q == 7'h00) begin
      ratio_q <= `PPC_DIV_BY_ONE; // RULE5
    end else begin
      ratio_q <= pdiv_q; // RULE6
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fb_mult_q <= `PPC_MULT_TWO;
      extv_div_q <= `PPC_MULT_ONE;
    end else begin
      fb_mult_q <= vcxo_q ? `PPC_MULT_TWO : `PPC_MULT_ONE; // RULE7
      extv_div_q <= extv_q ? `PPC_MULT_TWO : `PPC_MULT_ONE; // RULE8
    end
  end

  // Reference routing outside bypass mode would feed the channels an
  // unconditioned clock, so it falls back to the second loop and flags.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      route_q <= PPC_SRC_LOOP2;
      src_bad_q <= 1'b0;
    end else if (src_q == PPC_SRC_REF && !byp_q) begin
      route_q <= PPC_SRC_LOOP2; // RULE9
      src_bad_q <= 1'b1;
    end else begin
      route_q <= ppc_source_t'(src_q); // RULE10
      src_bad_q <= 1'b0;
    end
  end

  assign vcxo_tune_polarity = pol_q;
  assign force_midpoint_tune = force_q;
  assign first_loop_lock_enable = lock_en_q;
  assign pump_offset_code = ofs_q;
  assign pump_offset_na = ofs_na_q;
  assign doubler_select = dbl_q;
  assign second_stage_predivider = pdiv_q;
  assign predivide_ratio = ratio_q;
  assign vcxo_limit_div_select = vcxo_q;
  assign vcxo_feedback_mult = fb_mult_q;
  assign ext_vco_limit_div_select = extv_q;
  assign ext_vco_div_ratio = extv_div_q;
  assign output_source_select = ppc_source_t'(src_q);
  assign output_source_route = route_q;
  assign output_source_invalid = src_bad_q;
  assign first_stage_bypass_mode = byp_q;

endmodule

// ### shared/ppc_map.svh
// Overview of operation
// RULE1 - Polarity bit drives VCXO tune polarity: 0 positive, 1 negative; resets 0.
// RULE2 - Force-midpoint bit at 1 holds tune pin at half supply, loop unlocked; resets 1.
// RULE3 - Software clears force-midpoint after startup so the first loop can lock.
// RULE4 - 6-bit offset code weights 200,100,100,50,25,12.5 uA; resets zero.
// RULE5 - Doubler bit 0 uses predivider, 1 doubles and ignores predivider; resets 0.
// RULE6 - Predivider divides by its 7-bit value 1..127; value 1 bypasses; resets 1.
// RULE7 - VCXO limit bit 1 inserts divide-by-2 ahead of feedback divider; resets 1.
// RULE8 - External VCO limit bit 1 halves external VCO frequency; resets 0.
// RULE9 - Source select 00 ext VCO, 01 loop two, 10 loop one, 11 ref; resets 01.
// RULE10 - Mode bit 0 dual-loop, 1 synthesizer with first loop bypassed; resets 0.
// RULE11 - Reserved bits read zero, ignore writes; writes apply when serial write ends.
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PPC_ADDR_PUMP 7'h1D
`define PPC_ADDR_PREDIV 7'h20
`define PPC_ADDR_PATH 7'h21

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPC_PUMP_POL 7
`define PPC_PUMP_FORCE 6
`define PPC_PREDIV_DBL 7
`define PPC_PATH_VCXO 7
`define PPC_PATH_EXTV 6
`define PPC_PATH_SRC_HI 5
`define PPC_PATH_SRC_LO 4
`define PPC_PATH_BYP 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PPC_RST_POL 1'h0
`define PPC_RST_FORCE 1'h1
`define PPC_RST_OFFSET 6'h00
`define PPC_RST_DBL 1'h0
`define PPC_RST_PREDIV 7'h01
`define PPC_RST_VCXO 1'h1
`define PPC_RST_EXTV 1'h0
`define PPC_RST_SRC 2'h1
`define PPC_RST_BYP 1'h0

// ----------------------------------------
// Offset current steps of 12.5 uA, in nA
// ----------------------------------------
`define PPC_OFS_STEP_NA 19'h030D4
`define PPC_OFS_W5 6'h10
`define PPC_OFS_W4 6'h08
`define PPC_OFS_W3 6'h08
`define PPC_OFS_W2 6'h04
`define PPC_OFS_W1 6'h02
`define PPC_OFS_W0 6'h01

// ----------------------------------------
// Serial frame
// ----------------------------------------
`define PPC_CMD_LAST 4'h7
`define PPC_DATA_LAST 4'hF
`define PPC_DATA_FIRST 4'h8
`define PPC_PUMP_OFS_HI 5
`define PPC_PREDIV_HI 6
`define PPC_DIV_BY_ONE 7'h01
`define PPC_MULT_ONE 2'h1
`define PPC_MULT_TWO 2'h2

`endif

// ### shared/ppc_pkg.sv
package ppc_pkg;

  typedef enum logic [1:0] {
    PPC_SRC_EXT_VCO = 2'b00,
    PPC_SRC_LOOP2 = 2'b01,
    PPC_SRC_LOOP1 = 2'b10,
    PPC_SRC_REF = 2'b11
  } ppc_source_t;

  typedef enum logic [1:0] {
    PPC_SPI_CMD = 2'b00,
    PPC_SPI_DATA = 2'b01,
    PPC_SPI_DONE = 2'b10
  } ppc_spi_state_t;

endpackage

// ### sim/ppc_top_properties.sv
`timescale 1ns/1ps
module ppc_top_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_3wire,
  input wire logic spi_sdio_o,
  input wire logic spi_sdio_oe,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe,
  input wire logic vcxo_tune_polarity,
  input wire logic force_midpoint_tune,
  input wire logic first_loop_lock_enable,
  input wire logic [5:0] pump_offset_code,
  input wire logic [18:0] pump_offset_na,
  input wire logic doubler_select,
  input wire logic [6:0] second_stage_predivider,
  input wire logic [6:0] predivide_ratio,
  input wire logic vcxo_limit_div_select,
  input wire logic [1:0] vcxo_feedback_mult,
  input wire logic ext_vco_limit_div_select,
  input wire logic [1:0] ext_vco_div_ratio,
  input wire ppc_pkg::ppc_source_t output_source_select,
  input wire ppc_pkg::ppc_source_t output_source_route,
  input wire logic output_source_invalid,
  input wire logic first_stage_bypass_mode
);
  import ppc_pkg::*;
  logic [6:0] ofs_steps;
  logic [18:0] na_exp;
  logic [6:0] ratio_exp;
  logic bad_sel;
  ppc_source_t route_exp;
  logic [20:0] fields;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Expected decodes
  // ----------------------------------------
  // Bits 3 and 4 weigh the same, so the code is not plain binary.
  assign ofs_steps = {4'h0, pump_offset_code[2:0]}
    + {3'h0, pump_offset_code[3], 3'h0} + {3'h0, pump_offset_code[4], 3'h0}
    + {2'h0, pump_offset_code[5], 4'h0};
  assign na_exp = {12'h000, ofs_steps} * 19'h030D4;
  assign ratio_exp = (doubler_select || second_stage_predivider == 7'h00)
    ? 7'h01 : second_stage_predivider;
  assign bad_sel = output_source_select == PPC_SRC_REF
    && !first_stage_bypass_mode;
  assign route_exp = bad_sel ? PPC_SRC_LOOP2 : output_source_select;
  assign fields = {vcxo_tune_polarity, force_midpoint_tune, pump_offset_code,
    doubler_select, second_stage_predivider, vcxo_limit_div_select,
    ext_vco_limit_div_select, output_source_select, first_stage_bypass_mode};
  lock_follow_a: assert property (
    first_loop_lock_enable == !$past(force_midpoint_tune))
    else $error("lock enable does not follow force bit");
  offset_na_a: assert property (
    pump_offset_na == $past(na_exp))
    else $error("offset current wrong");
  ratio_map_a: assert property (
    predivide_ratio == $past(ratio_exp))
    else $error("predivide ratio wrong");
  vcxo_mult_a: assert property (
    vcxo_feedback_mult == ($past(vcxo_limit_div_select) ? 2'h2 : 2'h1))
    else $error("feedback multiplier wrong");
  ext_div_a: assert property (
    ext_vco_div_ratio == ($past(ext_vco_limit_div_select) ? 2'h2 : 2'h1))
    else $error("external divide wrong");
  route_map_a: assert property (
    output_source_route == $past(route_exp))
    else $error("source route wrong");
  invalid_flag_a: assert property (
    output_source_invalid == $past(bad_sel))
    else $error("invalid flag wrong");
  oe_side_a: assert property (
    (spi_sdio_oe |-> spi_3wire && !spi_sdo_oe)
    and (spi_sdo_oe |-> !spi_3wire))
    else $error("wrong data pin enabled");
  oe_release_a: assert property (
    spi_cs_n [*4] |-> !spi_sdio_oe && !spi_sdo_oe)
    else $error("pin driven without select");
  pins_same_a: assert property (spi_sdo_o == spi_sdio_o)
    else $error("data pins differ");
  idle_hold_a: assert property (
    spi_cs_n [*8] |=> $stable(fields))
    else $error("field changed without frame");
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  import ppc_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, spi_sclk = 1'b0, spi_cs_n = 1'b1;
  logic spi_sdio_i = 1'b0, spi_3wire = 1'b0;
  logic spi_sdio_o, spi_sdio_oe, spi_sdo_o, spi_sdo_oe;
  logic vcxo_tune_polarity, force_midpoint_tune, first_loop_lock_enable;
  logic doubler_select, vcxo_limit_div_select, ext_vco_limit_div_select;
  logic output_source_invalid, first_stage_bypass_mode;
  logic [5:0] pump_offset_code;
  logic [18:0] pump_offset_na;
  logic [6:0] second_stage_predivider, predivide_ratio;
  logic [1:0] vcxo_feedback_mult, ext_vco_div_ratio, s;
  ppc_source_t output_source_select, output_source_route;
  logic [7:0] q, d;
  int error_cnt = 0;
  int comparisons = 0;
  logic [18:0] w [6] = '{19'h030D4, 19'h061A8, 19'h0C350, 19'h186A0,
    19'h186A0, 19'h30D40};
  logic [7:0] pv [4] = '{8'h7F, 8'hFF, 8'h00, 8'h01};
  logic [6:0] pr [4] = '{7'h7F, 7'h01, 7'h01, 7'h01};
  ppc_top i_ppc_top (.mclk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_sdio_i,
    .spi_3wire, .spi_sdio_o, .spi_sdio_oe, .spi_sdo_o, .spi_sdo_oe,
    .vcxo_tune_polarity, .force_midpoint_tune, .first_loop_lock_enable,
    .pump_offset_code, .pump_offset_na, .doubler_select,
    .second_stage_predivider, .predivide_ratio, .vcxo_limit_div_select,
    .vcxo_feedback_mult, .ext_vco_limit_div_select, .ext_vco_div_ratio,
    .output_source_select, .output_source_route, .output_source_invalid,
    .first_stage_bypass_mode);
  initial begin
    forever #10 mclk = ~mclk;
  end
  // ----------------------------------------
  // Serial access and checking
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // Each sclk phase lasts 5 mclk so the 3-flop input path always settles.
  task automatic xfer(input logic [15:0] f, input int nb);
    q = 8'h00;
    spi_cs_n <= 1'b0;
    repeat (5) @(posedge mclk);
    for (int i = 15; i > 15 - nb; i--) begin
      spi_sclk <= 1'b0;
      spi_sdio_i <= f[i];
      repeat (5) @(posedge mclk);
      if (i < 8) q[i] = spi_3wire ? spi_sdio_o : spi_sdo_o;
      if (i == 0 && f[15]) chk({spi_sdio_oe, spi_sdo_oe}, {spi_3wire, ~spi_3wire});
      spi_sclk <= 1'b1;
      repeat (5) @(posedge mclk);
    end
    spi_sclk <= 1'b0;
    repeat (5) @(posedge mclk);
    spi_cs_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    xfer({1'b0, a, v}, 16);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    xfer({1'b1, a, 8'h00}, 16);
    chk(q, e);
  endtask
  task automatic final_report;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #500000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({vcxo_tune_polarity, force_midpoint_tune, first_loop_lock_enable}, 3'h2);
    chk({pump_offset_code, pump_offset_na}, 25'h0);
    chk({doubler_select, second_stage_predivider, predivide_ratio}, 15'h0081);
    chk({vcxo_limit_div_select, vcxo_feedback_mult}, 3'h6);
    chk({ext_vco_limit_div_select, ext_vco_div_ratio}, 3'h1);
    chk({output_source_select, output_source_route, output_source_invalid}, 5'h0A);
    chk(first_stage_bypass_mode, 1'h0);
    rd(7'h1D, 8'h40);
    rd(7'h20, 8'h01);
    rd(7'h21, 8'h90);
    $display("test reset_values done");
    wr(7'h1D, 8'h80);
    chk({vcxo_tune_polarity, force_midpoint_tune, first_loop_lock_enable}, 3'h5);
    for (int k = 0; k < 6; k++) begin
      wr(7'h1D, 8'h01 << k);
      chk(pump_offset_na, w[k]);
    end
    wr(7'h1D, 8'h3F);
    chk(pump_offset_na, 19'h7704C);
    rd(7'h1D, 8'h3F);
    wr(7'h1D, 8'h40);
    chk({force_midpoint_tune, first_loop_lock_enable}, 2'h2);
    $display("test pump done");
    for (int k = 0; k < 4; k++) begin
      wr(7'h20, pv[k]);
      chk({doubler_select, second_stage_predivider}, pv[k]);
      chk(predivide_ratio, pr[k]);
      rd(7'h20, pv[k]);
    end
    $display("test predivider done");
    for (int k = 0; k < 16; k++) begin
      s = k[2:1];
      d = {k[0], ~k[0], s, k[3], 3'h7};
      wr(7'h21, d);
      chk({vcxo_limit_div_select, ext_vco_limit_div_select, output_source_select, first_stage_bypass_mode}, d[7:3]);
      chk({vcxo_feedback_mult, ext_vco_div_ratio}, k[0] ? 4'h9 : 4'h6);
      chk({output_source_route, output_source_invalid}, (s == 2'h3 && !k[3]) ? 3'h3 : {s, 1'b0});
      rd(7'h21, d & 8'hF8);
    end
    $display("test path done");
    wr(7'h22, 8'hFF);
    rd(7'h22, 8'h00);
    xfer({1'b0, 7'h21, 8'h00}, 10);
    rd(7'h21, 8'hB8);
    spi_3wire <= 1'b1;
    rd(7'h20, 8'h01);
    spi_3wire <= 1'b0;
    $display("test refuse done");
    wr(7'h1D, 8'hBF);
    wr(7'h20, 8'hFF);
    sys_rst <= 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(7'h21, 8'h90);
    rd(7'h1D, 8'h40);
    rd(7'h20, 8'h01);
    chk(first_loop_lock_enable, 1'b0);
    $display("test second_reset done");
    final_report;
  end
endmodule
bind ppc_top ppc_top_properties i_ppc_top_properties (.mclk, .sys_rst,
  .spi_cs_n, .spi_3wire, .spi_sdio_o, .spi_sdio_oe, .spi_sdo_o, .spi_sdo_oe,
  .vcxo_tune_polarity, .force_midpoint_tune, .first_loop_lock_enable,
  .pump_offset_code, .pump_offset_na, .doubler_select,
  .second_stage_predivider, .predivide_ratio, .vcxo_limit_div_select,
  .vcxo_feedback_mult, .ext_vco_limit_div_select, .ext_vco_div_ratio,
  .output_source_select, .output_source_route, .output_source_invalid,
  .first_stage_bypass_mode);
